// ---- pwo_pkg.sv ----
// Package: register map, field layout, period table and timing constants of the PWM output channel
package pwo_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int ADDR_W = 4;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_CODE = 4'h1;
  localparam logic [3:0] REG_DUTY = 4'h2;
  localparam logic [3:0] REG_STAT = 4'h3;
  localparam logic [3:0] REG_IRQ_STAT = 4'h4;
  localparam logic [3:0] REG_IRQ_MASK = 4'h5;
  localparam logic [3:0] REG_PERIOD = 4'h6;
  localparam int CTRL_FUNC_BIT = 0;
  localparam int CTRL_SW_EN_BIT = 1;
  localparam int STAT_RUN_BIT = 0;
  localparam int STAT_ERR_BIT = 1;
  localparam int STAT_PIN_BIT = 2;
  localparam int STAT_EN_BIT = 3;
  localparam int IRQ_START_ERR = 0;
  localparam int IRQ_CLAMP = 1;
  localparam int IRQ_DONE = 2;
  localparam int IRQ_W = 3;
  localparam int CODE_W = 5;
  localparam int DUTY_W = 16;
  localparam logic [4:0] CODE_LAST_FINE = 5'h13;
  localparam logic [4:0] CODE_LAST = 5'h18;
  localparam logic [15:0] DUTY_MAX_FINE = 16'h03E7;
  localparam logic [15:0] DUTY_MAX_COARSE = 16'h03DE;
  localparam logic [15:0] DUTY_STEP_COARSE = 16'h000A;
  localparam logic [15:0] RES_FINE = 16'h03E8;
  localparam logic [15:0] RES_COARSE = 16'h0064;
  localparam int PER_W = 27;
  // Period table in tens of nanoseconds (hundredths of a microsecond)
  localparam int PER_TAB_10NS [0:24] = '{
    66_667_000, 50_251_000, 24_570_000, 16_393_000, 12_285_000,
    10_235_000, 5_120_000, 2_048_000, 1_024_000, 496_000,
    248_000, 200_000, 144_000, 96_000, 80_000,
    64_000, 48_000, 32_000, 16_000, 8_000,
    6_000, 5_000, 4_000, 3_000, 2_000};
  localparam int NS_PER_UNIT = 10;
  localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_ERR = 3'b100
  } pwo_state_t;
endpackage

// ---- pwo_sync.sv ----
// Three-flop synchroniser for an external level, change accepted when stages two and three agree
`timescale 1ns/1ps
module pwo_sync
(
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic din,
  output logic dout
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      dout <= 1'b0;
    end
    else if (ce)
    begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r)
      begin
        dout <= s3_r;
      end
    end
  end
endmodule

// ---- pwo_channel.sv ----
// PWM output channel: Avalon-MM registers, period table, duty handling and pulse generation
// Behaviour
// - While started, drive the output pin with the selected period and duty.
// - Codes 0..19 pick resolution-1000 periods; duty 0..999 is 0.1 percent steps.
// - Codes 20..24 pick resolution-100 periods; duty 0..990 is 0..99 percent.
// - At resolution 100 duty moves in steps of ten; remainder is dropped.
// - Out-of-range duty during a run keeps running, clamped to maximum.
// - Out-of-range duty at start raises an operation error, no output.
// - Output lasts only while the enable condition holds.
`timescale 1ns/1ps
module pwo_channel
#(
  parameter int PER_W_P = pwo_pkg::PER_W
)
(
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [pwo_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic enable_input,
  output logic pwm_output_pin,
  output logic irq
);
  import pwo_pkg::*;

  // Codes past the table end are clamped here; the start logic refuses them separately
  function automatic logic [PER_W_P-1:0] period_cycles(input logic [CODE_W-1:0] code);
    int idx;
    idx = int'(code);
    if (idx > int'(CODE_LAST))
    begin
      idx = int'(CODE_LAST);
    end
    period_cycles = PER_W_P'(PER_TAB_10NS[idx] * NS_PER_UNIT / CLK_PERIOD_NS);
  endfunction

  function automatic logic is_coarse(input logic [CODE_W-1:0] code);
    is_coarse = (code > CODE_LAST_FINE);
  endfunction

  function automatic logic duty_bad(input logic [CODE_W-1:0] code, input logic [DUTY_W-1:0] d);
    duty_bad = is_coarse(code) ? (d > DUTY_MAX_COARSE) : (d > DUTY_MAX_FINE);
  endfunction

  function automatic logic start_bad(input logic [CODE_W-1:0] code, input logic [DUTY_W-1:0] d);
    start_bad = duty_bad(code, d) || (code > CODE_LAST);
  endfunction

  logic func_sel_r;
  logic sw_en_r;
  logic [CODE_W-1:0] code_r;
  logic [DUTY_W-1:0] duty_r;
  logic [IRQ_W-1:0] irq_stat_r;
  logic [IRQ_W-1:0] irq_mask_r;
  logic [IRQ_W-1:0] ev_nxt;
  logic en_sync;
  logic go;
  logic go_d_r;
  logic ack_r;
  pwo_state_t state_r;
  logic [CODE_W-1:0] run_code_r;
  logic [PER_W_P-1:0] per_cnt_r;
  logic [PER_W_P-1:0] per_len_r;
  logic [PER_W_P-1:0] high_len_r;
  logic [PER_W_P-1:0] high_nxt;
  logic [DUTY_W-1:0] duty_eff;
  logic clamp_now;
  logic [PER_W_P+DUTY_W-1:0] prod;
  logic [PER_W_P-1:0] per_sel;

  pwo_sync u_en_sync
  (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .din(enable_input),
    .dout(en_sync)
  );

  // Start condition: function selected, software enable set and enable input held
  assign go = en_sync && sw_en_r && func_sel_r;

  // Duty clamp and resolution-100 truncation
  always_comb
  begin
    clamp_now = duty_bad(run_code_r, duty_r);
    duty_eff = duty_r;
    if (is_coarse(run_code_r))
    begin
      if (clamp_now)
      begin
        duty_eff = DUTY_MAX_COARSE;
      end
      else
      begin
        duty_eff = duty_r - (duty_r % DUTY_STEP_COARSE);
      end
    end
    else if (clamp_now)
    begin
      duty_eff = DUTY_MAX_FINE;
    end
    per_sel = period_cycles(run_code_r);
    // Coarse duty counts whole percent steps against a resolution of 100
    if (is_coarse(run_code_r))
    begin
      prod = (PER_W_P+DUTY_W)'(per_sel) * (PER_W_P+DUTY_W)'(duty_eff / DUTY_STEP_COARSE);
    end
    else
    begin
      prod = (PER_W_P+DUTY_W)'(per_sel) * (PER_W_P+DUTY_W)'(duty_eff);
    end
    if (is_coarse(run_code_r))
    begin
      high_nxt = PER_W_P'(prod / (PER_W_P+DUTY_W)'(RES_COARSE));
    end
    else
    begin
      high_nxt = PER_W_P'(prod / (PER_W_P+DUTY_W)'(RES_FINE));
    end
  end

  // Run state machine
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_r <= ST_IDLE;
      run_code_r <= '0;
      go_d_r <= 1'b0;
    end
    else if (ce)
    begin
      go_d_r <= go;
      case (state_r)
        ST_IDLE:
        begin
          run_code_r <= code_r;
          if (go && !go_d_r)
          begin
            if (start_bad(code_r, duty_r))
            begin
              state_r <= ST_ERR;
            end
            else
            begin
              state_r <= ST_RUN;
            end
          end
        end
        ST_RUN:
        begin
          if (!go)
          begin
            state_r <= ST_IDLE;
          end
        end
        ST_ERR:
        begin
          if (!go)
          begin
            state_r <= ST_IDLE;
          end
        end
        default:
        begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Period counter; duty latched only at period boundary
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      per_cnt_r <= '0;
      per_len_r <= '0;
      high_len_r <= '0;
      pwm_output_pin <= 1'b0;
    end
    else if (ce)
    begin
      if (state_r != ST_RUN || !go)
      begin
        // Preload the last count so the first run cycle opens a full period
        per_cnt_r <= per_sel - PER_W_P'(1);
        per_len_r <= per_sel;
        high_len_r <= high_nxt;
        pwm_output_pin <= 1'b0;
      end
      else
      begin
        if (per_cnt_r >= per_len_r - PER_W_P'(1))
        begin
          per_cnt_r <= '0;
          per_len_r <= per_sel;
          high_len_r <= high_nxt;
          pwm_output_pin <= (high_nxt != '0);
        end
        else
        begin
          per_cnt_r <= per_cnt_r + PER_W_P'(1);
          pwm_output_pin <= (per_cnt_r + PER_W_P'(1)) < high_len_r;
        end
      end
    end
  end

  // Interrupt events
  always_comb
  begin
    ev_nxt = '0;
    ev_nxt[IRQ_START_ERR] = (state_r == ST_IDLE) && go && !go_d_r && start_bad(code_r, duty_r);
    ev_nxt[IRQ_CLAMP] = (state_r == ST_RUN) && clamp_now;
    ev_nxt[IRQ_DONE] = (state_r == ST_RUN) && !go;
  end

  // Bus slave: one wait cycle per access, answer on second cycle
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ack_r <= 1'b0;
    end
    else if (ce)
    begin
      ack_r <= (avs_read || avs_write) && !ack_r;
    end
  end

  // Waitrequest kept in a flop: always the inverse of the next value of ack_r
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      avs_waitrequest <= 1'b1;
    end
    else if (ce)
    begin
      avs_waitrequest <= !((avs_read || avs_write) && !ack_r);
    end
  end

  // Configuration registers
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      func_sel_r <= 1'b0;
      sw_en_r <= 1'b0;
      code_r <= '0;
      duty_r <= '0;
      irq_mask_r <= '0;
    end
    else if (ce && avs_write && ack_r && avs_byteenable[0])
    begin
      case (avs_address)
        REG_CTRL:
        begin
          func_sel_r <= avs_writedata[CTRL_FUNC_BIT];
          sw_en_r <= avs_writedata[CTRL_SW_EN_BIT];
        end
        REG_CODE:
        begin
          code_r <= avs_writedata[CODE_W-1:0];
        end
        REG_DUTY:
        begin
          duty_r[7:0] <= avs_writedata[7:0];
          if (avs_byteenable[1])
          begin
            duty_r[15:8] <= avs_writedata[15:8];
          end
        end
        REG_IRQ_MASK:
        begin
          irq_mask_r <= avs_writedata[IRQ_W-1:0];
        end
        default:
        begin
        end
      endcase
    end
  end

  // Sticky status, write one to clear, set wins
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      irq_stat_r <= '0;
      irq <= 1'b0;
    end
    else if (ce)
    begin
      if (avs_write && ack_r && avs_byteenable[0] && avs_address == REG_IRQ_STAT)
      begin
        irq_stat_r <= (irq_stat_r & ~avs_writedata[IRQ_W-1:0]) | ev_nxt;
      end
      else
      begin
        irq_stat_r <= irq_stat_r | ev_nxt;
      end
      irq <= |((irq_stat_r | ev_nxt) & irq_mask_r);
    end
  end

  // Read data
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      avs_readdata <= '0;
    end
    else if (ce)
    begin
      avs_readdata <= '0;
      if (avs_read && !ack_r)
      begin
        case (avs_address)
          REG_CTRL: avs_readdata <= {30'h0, sw_en_r, func_sel_r};
          REG_CODE: avs_readdata <= {27'h0, code_r};
          REG_DUTY: avs_readdata <= {16'h0, duty_r};
          REG_STAT: avs_readdata <= {28'h0, en_sync, pwm_output_pin, state_r == ST_ERR, state_r == ST_RUN};
          REG_IRQ_STAT: avs_readdata <= {29'h0, irq_stat_r};
          REG_IRQ_MASK: avs_readdata <= {29'h0, irq_mask_r};
          REG_PERIOD: avs_readdata <= 32'(per_len_r);
          default: avs_readdata <= '0;
        endcase
      end
    end
  end
endmodule

// ---- pwo_channel_checker.sv ----
// Checker: bus handshake and output pin timing of the PWM channel
`timescale 1ns/1ps
module pwo_channel_checker
(
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [pwo_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic enable_input,
  input wire logic pwm_output_pin,
  input wire logic irq
);
  import pwo_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  wire logic req = avs_read | avs_write;
  a_one_wait_state: assert property (req && !$past(req) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus answer not after one wait state");
  a_idle_wait_high: assert property (!req |-> avs_waitrequest) else $error("answer without request");
  a_rdata_zero_idle: assert property (avs_waitrequest |-> avs_readdata == 32'h0) else $error("read data not zero");
  a_ack_has_cause: assert property (!avs_waitrequest |-> $past(req)) else $error("answer without cause");
  a_ack_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("answer held too long");
  a_high_min_len: assert property ($rose(pwm_output_pin) |-> pwm_output_pin [*8])
    else $error("high pulse too short");
  a_low_min_len: assert property ($fell(pwm_output_pin) |-> !pwm_output_pin [*8])
    else $error("low gap too short");
  a_pin_off_disabled: assert property (!enable_input [*8] |-> ##2 !pwm_output_pin)
    else $error("pin active without enable");
  a_reset_quiet: assert property ($fell(srst) |-> !pwm_output_pin && !irq && avs_waitrequest)
    else $error("outputs not quiet after reset");
endmodule
bind pwo_channel pwo_channel_checker chk_u (.clk(clk), .srst(srst), .ce(ce), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .enable_input(enable_input),
  .pwm_output_pin(pwm_output_pin), .irq(irq));

// ---- pwo_load.sv ----
// Load model: measures period and high time seen on the output pin
`timescale 1ns/1ps
module pwo_load
(
  input wire logic clk,
  input wire logic pin,
  output logic fresh,
  output logic [31:0] per_cnt,
  output logic [31:0] hi_cnt
);
  logic pin_r;
  logic [31:0] cnt_r;
  logic [31:0] hi_r;
  always_ff @(posedge clk)
  begin
    pin_r <= pin;
    fresh <= pin & ~pin_r;
    if (pin & ~pin_r)
    begin
      per_cnt <= cnt_r;
      hi_cnt <= hi_r;
      cnt_r <= 32'h1;
      hi_r <= 32'h1;
    end
    else
    begin
      cnt_r <= cnt_r + 32'h1;
      hi_r <= hi_r + {31'h0, pin};
    end
  end
endmodule

// ---- pwo_channel_bench.sv ----
// Testbench: PWM channel scenarios driven over the register bus
`timescale 1ns/1ps
module pwo_channel_bench;
  import pwo_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic enable_input = 1'b0;
  logic pwm_output_pin;
  logic irq;
  logic fresh;
  logic [31:0] per_cnt;
  logic [31:0] hi_cnt;
  logic [31:0] q;
  int n_fail = 0;
  int checks = 0;
  always #5 clk = ~clk;
  pwo_channel dut_u (.clk(clk), .srst(srst), .ce(1'b1), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .enable_input(enable_input), .pwm_output_pin(pwm_output_pin), .irq(irq));
  pwo_load load_u (.clk(clk), .pin(pwm_output_pin), .fresh(fresh), .per_cnt(per_cnt), .hi_cnt(hi_cnt));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %0h, expected %0h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    chk({31'h0, n == 50}, 32'h0);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  task automatic meas(input int n, input logic [31:0] per, input logic [31:0] hi);
    repeat (n) @(posedge fresh);
    @(posedge clk);
    chk(per_cnt, per);
    chk(hi_cnt, hi);
  endtask
  task automatic run(input logic [4:0] c, input logic [15:0] d);
    bus(1'b1, REG_CODE, {27'h0, c});
    bus(1'b1, REG_DUTY, {16'h0, d});
    @(posedge clk);
    enable_input <= 1'b1;
  endtask
  task automatic halt;
    @(posedge clk);
    enable_input <= 1'b0;
    repeat (20) @(posedge clk);
  endtask
  task automatic t_regs;
    rd(4'h7, 32'h0);
    bus(1'b1, 4'h9, 32'h5);
    rd(4'h9, 32'h0);
    bus(1'b1, REG_IRQ_MASK, 32'h7);
    rd(REG_IRQ_MASK, 32'h7);
    bus(1'b1, REG_CTRL, 32'h3);
    rd(REG_CTRL, 32'h3);
    $display("test regs done");
  endtask
  task automatic t_fine;
    run(CODE_LAST_FINE, 16'h1F4);
    meas(2, 32'h1F40, 32'hFA0);
    bus(1'b1, REG_DUTY, 32'hFA);
    meas(1, 32'h1F40, 32'hFA0);
    meas(1, 32'h1F40, 32'h7D0);
    bus(1'b1, REG_DUTY, 32'h5DC);
    meas(2, 32'h1F40, 32'h1F38);
    chk({31'h0, irq}, 32'h1);
    halt;
    chk({31'h0, pwm_output_pin}, 32'h0);
    rd(REG_STAT, 32'h0);
    rd(REG_IRQ_STAT, 32'h6);
    bus(1'b1, REG_IRQ_STAT, 32'h7);
    rd(REG_IRQ_STAT, 32'h0);
    chk({31'h0, irq}, 32'h0);
    $display("test fine done");
  endtask
  task automatic t_coarse;
    // Single channel here, not a medium-speed one, so codes 20 to 24 are allowed
    for (int c = 20; c <= 24; c++)
    begin
      run(5'(c), 16'h1F9);
      meas(2, 32'(PER_TAB_10NS[c] * NS_PER_UNIT / CLK_PERIOD_NS),
        32'(PER_TAB_10NS[c] * NS_PER_UNIT / CLK_PERIOD_NS / 2));
      rd(REG_PERIOD, 32'(PER_TAB_10NS[c] * NS_PER_UNIT / CLK_PERIOD_NS));
      halt;
    end
    $display("test coarse done");
  endtask
  task automatic t_err;
    bus(1'b1, REG_IRQ_STAT, 32'h7);
    run(CODE_LAST_FINE, 16'h3E8);
    repeat (20) @(posedge clk);
    chk({31'h0, pwm_output_pin}, 32'h0);
    rd(REG_STAT, 32'hA);
    rd(REG_IRQ_STAT, 32'h1);
    halt;
    run(5'h14, 16'h3DF);
    repeat (20) @(posedge clk);
    rd(REG_STAT, 32'hA);
    halt;
    run(5'h19, 16'h0);
    repeat (20) @(posedge clk);
    rd(REG_STAT, 32'hA);
    halt;
    $display("test error done");
  endtask
  task automatic final_report;
    $display("checks %0d, mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    t_regs;
    t_fine;
    t_coarse;
    t_err;
    final_report;
  end
  initial
  begin
    #900000;
    n_fail++;
    final_report;
  end
endmodule
